// [verilog/pwm_tone_pkg.sv]
// Package with register map, field layout and types for the PWM and tone generator
package pwm_tone_pkg;
	localparam logic [7:0]  CONTROL_ADDR  = 8'ha1; // Byte address of waveform_control
	localparam logic [7:0]  LOW_ADDR      = 8'ha4; // Byte address of value_low_byte
	localparam logic [7:0]  HIGH_ADDR     = 8'ha8; // Byte address of value_upper_byte
	localparam logic [7:0]  PINCFG_ADDR   = 8'hac; // Pin latch, pin mode and power down
	localparam logic [7:0]  STATUS_ADDR   = 8'hb0; // Live output state
	localparam logic [7:0]  CONTROL_RESET = 8'h00;
	localparam logic [7:0]  PINCFG_RESET  = 8'h01; // Latch set, push-pull, powered
	localparam logic [15:0] VALUE_RESET   = 16'h0000;
	localparam logic [15:0] COUNT_ZERO    = 16'h0000;
	localparam logic [15:0] COUNT_ONE     = 16'h0001;
	localparam logic [16:0] WIDE_ONE      = 17'h00001;
	localparam logic [7:0]  BYTE_ZERO     = 8'h00;
	localparam int          POL_BIT       = 5;
	localparam int          SEL_BIT       = 4;
	localparam int          SPD_BIT       = 3;
	localparam int          LATCH_BIT     = 0;
	localparam int          OPEN_BIT      = 1; // 1 = pin not configured as push-pull output
	localparam int          PDOWN_BIT     = 4; // Power-down bit, same position as in power_control
	localparam logic [2:0]  MODE_OFF      = 3'h0;
	localparam logic [2:0]  MODE_PWM      = 3'h1;
	localparam logic [2:0]  MODE_SQUARE   = 3'h3;
	localparam logic [2:0]  MODE_STAIR    = 3'h7;
	localparam logic [1:0]  PHASE_SHIFT   = 2'h2; // Quarter of a half period

	typedef struct packed {
		logic       drive;
		logic       level;
	} pin_drive_t;
endpackage

// [verilog/pwm_tone_generator.sv]
// PWM and tone generator with a classic Wishbone register slave
// Operation
// - Mode 000 off, 001 PWM, 011 square tone, 111 staircase tone
// - Mode bit 0 clear keeps the generator completely idle
// - Mode bit 1 picks PWM when 0, tone when 1
// - Control bit 4 steers byte pair to period (0) or duty (1)
// - Control bit 3 picks microsecond tick (0) or system clock (1)
// - Control bit 5 makes duty the high time (0) or low time (1)
// - PWM cycle lasts period plus one ticks, duty restarts each cycle
// - Polarity 0: duty zero low, duty above period high, else high duty ticks
// - Polarity 1: duty zero high, duty above period low, else low duty ticks
// - Square tone is fifty percent, full period twice the period value
// - Staircase drives high impedance in last quarter of each half period
// - Byte pair forms one 16-bit value, target chosen at write time
// - Waveform reaches the pin only when it is a push-pull output
// - Output suppressed unless the pin latch bit is one
// - Generator runs only while the power-down bit is clear
//
// Added by the designer: the Wishbone slave port.
`timescale 1ns/100ps
module pwm_tone_generator
	import pwm_tone_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        microsecond_tick_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             pin_o,
	output logic             pin_oe_o
);
	// State held in flip-flops
	logic [7:0]  waveform_control_reg;
	logic [7:0]  pin_config_reg;
	logic [15:0] period_reg;
	logic [15:0] duty_reg;
	logic [7:0]  low_hold_reg;
	logic [15:0] count_reg;
	logic        phase_reg;
	logic        ack_reg;
	logic [31:0] rdata_reg;
	logic        tick_s1_reg;
	logic        tick_s2_reg;
	logic        tick_s3_reg;
	pin_drive_t  out_reg;

	// Combinational views, decodes and strobes
	pin_drive_t  out_next;
	logic [2:0]  waveform_mode_field;
	logic        duty_polarity;
	logic        duty_period_select;
	logic        tick_speed_select;
	logic        running;
	logic        tick;
	logic        req;
	logic        byte0_wr;
	logic        pin_enabled;
	logic        pwm_wrap;
	logic        tone_wrap;
	logic        duty_zero;
	logic        duty_full;
	logic [15:0] quiet_start;

	// Address match for one register, shared by the write and read decoders
	function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
		return a == target;
	endfunction

	// Field views of the control register and bus strobes
	// Writes commit on the acked edge, the one at which the master samples ack high
	assign waveform_mode_field = waveform_control_reg[2:0];
	assign duty_polarity       = waveform_control_reg[POL_BIT];
	assign duty_period_select  = waveform_control_reg[SEL_BIT];
	assign tick_speed_select   = waveform_control_reg[SPD_BIT];
	assign req                 = wb_cyc_i && wb_stb_i && !ack_reg;
	assign byte0_wr            = wb_cyc_i && wb_stb_i && ack_reg && wb_we_i && wb_sel_i[0];

	// Tick comes from another divider domain, so it is synchronised first
	// Stage three only feeds the edge detector, never the raw input
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			tick_s1_reg <= 1'b0;
			tick_s2_reg <= 1'b0;
			tick_s3_reg <= 1'b0;
		end
		else
		begin
			tick_s1_reg <= microsecond_tick_i;
			tick_s2_reg <= tick_s1_reg;
			tick_s3_reg <= tick_s2_reg;
		end
	end

	// In system clock speed every cycle counts; the microsecond input must stay well below half the clock
	// tick base select
	assign tick = tick_speed_select ? 1'b1 : (tick_s2_reg && !tick_s3_reg);

	assign running = waveform_mode_field[0] && !pin_config_reg[PDOWN_BIT];

	// latch must be set
	// Latch and pin-mode gating sits after the counter, so a pin re-enabled by them joins the cycle wherever it is
	assign pin_enabled = running && pin_config_reg[LATCH_BIT] && !pin_config_reg[OPEN_BIT];

	// Wishbone ack: one cycle per request, dropped the cycle after
	// Registering ack costs a cycle but keeps the decode off the bus return path
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ack_reg <= 1'b0;
		else
			ack_reg <= req;
	end
	assign wb_ack_o = ack_reg;

	// Control and pin configuration registers
	// Unused upper bits are stored as zero so reads come back clean
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			waveform_control_reg <= CONTROL_RESET;
			pin_config_reg       <= PINCFG_RESET;
		end
		else if (byte0_wr)
		begin
			if (hit(wb_adr_i, CONTROL_ADDR))
				waveform_control_reg <= {2'h0, wb_dat_i[5:0]};
			else if (hit(wb_adr_i, PINCFG_ADDR))
				pin_config_reg <= {3'h0, wb_dat_i[4:0]};
		end
	end

	// byte pair as one value
	// Low byte is held until the high byte write commits both halves,
	// so the counter never sees a half-updated value.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			low_hold_reg <= BYTE_ZERO;
		else if (byte0_wr && hit(wb_adr_i, LOW_ADDR))
			low_hold_reg <= wb_dat_i[7:0];
	end

	// period or duty target
	// The high byte write commits both halves in one edge
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			period_reg <= VALUE_RESET;
			duty_reg   <= VALUE_RESET;
		end
		else if (byte0_wr && hit(wb_adr_i, HIGH_ADDR))
		begin
			if (duty_period_select)
				duty_reg <= {wb_dat_i[7:0], low_hold_reg};
			else
				period_reg <= {wb_dat_i[7:0], low_hold_reg};
		end
	end

	// Read data, unmapped addresses read zero
	// Byte pair reads show the selected register live, never the held low byte
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			rdata_reg <= 32'h0000_0000;
		else if (req && !wb_we_i)
		begin
			if (hit(wb_adr_i, CONTROL_ADDR))
				rdata_reg <= {24'h000000, waveform_control_reg};
			else if (hit(wb_adr_i, LOW_ADDR))
				rdata_reg <= {24'h000000, duty_period_select ? duty_reg[7:0] : period_reg[7:0]};
			else if (hit(wb_adr_i, HIGH_ADDR))
				rdata_reg <= {24'h000000, duty_period_select ? duty_reg[15:8] : period_reg[15:8]};
			else if (hit(wb_adr_i, PINCFG_ADDR))
				rdata_reg <= {24'h000000, pin_config_reg};
			else if (hit(wb_adr_i, STATUS_ADDR))
				rdata_reg <= {29'h00000000, running, out_reg.drive, out_reg.level};
			else
				rdata_reg <= 32'h0000_0000;
		end
	end
	assign wb_dat_o = rdata_reg;

	// PWM wraps after period plus one ticks
	assign pwm_wrap  = count_reg >= period_reg;
	// tone half period ends after period ticks; the extra bit keeps the sum from wrapping
	assign tone_wrap = ({1'b0, count_reg} + WIDE_ONE) >= {1'b0, period_reg};

	// Tick counter and tone half-period phase
	// Disabling clears the count so the next enable starts a fresh cycle
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			count_reg <= COUNT_ZERO;
			phase_reg <= 1'b0;
		end
		else if (!running)
		begin
			count_reg <= COUNT_ZERO;
			phase_reg <= 1'b0;
		end
		else if (tick)
		begin
			if (!waveform_mode_field[1])
			begin
				if (pwm_wrap)
					count_reg <= COUNT_ZERO;
				else
					count_reg <= count_reg + COUNT_ONE;
			end
			else
			begin
				if (tone_wrap)
				begin
					count_reg <= COUNT_ZERO;
					phase_reg <= !phase_reg;
				end
				else
					count_reg <= count_reg + COUNT_ONE;
			end
		end
	end

	// duty zero and duty above period pin the level
	// the same two ends, mirrored by the polarity bit
	assign duty_zero = duty_reg == COUNT_ZERO;
	assign duty_full = duty_reg > period_reg;

	// start of the last quarter of the half period, quarter rounded down
	assign quiet_start = period_reg - (period_reg >> PHASE_SHIFT);

	// Waveform selection
	always_comb
	begin
		out_next.drive = 1'b1;
		out_next.level = 1'b0;
		// PWM or tone
		// Only the three listed mode codes drive the pin
		case (waveform_mode_field)
			MODE_PWM:
			begin
				if (duty_zero)
					out_next.level = duty_polarity;
				else if (duty_full)
					out_next.level = !duty_polarity;
				else
					out_next.level = (count_reg < duty_reg) ^ duty_polarity;
			end
			MODE_SQUARE:
				out_next.level = phase_reg;
			MODE_STAIR:
			begin
				out_next.level = phase_reg;
				if (count_reg >= quiet_start)
					out_next.drive = 1'b0;
			end
			// Mode 101 and unlisted codes leave the pin undriven
			default:
				out_next.drive = 1'b0;
		endcase
	end

	// Pin register: idle leaves the pin undriven for the external pull-up
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			out_reg.drive <= 1'b0;
			out_reg.level <= 1'b0;
		end
		else if (!pin_enabled)
		begin
			out_reg.drive <= 1'b0;
			out_reg.level <= 1'b0;
		end
		else
			out_reg <= out_next;
	end
	// Pin level and enable come straight from flip-flops
	assign pin_o    = out_reg.level;
	assign pin_oe_o = out_reg.drive;
endmodule

// [dv/pwm_load_model.sv]
// Speaker load on the output pin with a pull-up
`timescale 1ns/100ps
module pwm_load_model
(
	input  wire logic pin_i,
	input  wire logic oe_i,
	output logic      level_o
);
	// Undriven pin floats to the pull-up level
	assign level_o = oe_i ? pin_i : 1'b1;
endmodule

// [dv/pwm_tone_checker.sv]
// Checker for bus handshake and pin drive rules
`timescale 1ns/100ps
module pwm_tone_checker
	import pwm_tone_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [31:0] wb_dat_o,
	input  wire logic        wb_ack_o,
	input  wire logic        pin_oe_o
);
	logic [7:0] ctl_reg;
	logic [7:0] cfg_reg;
	// Shadows update on the acked write edge; four cycles cover the pin register delay
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ctl_reg <= CONTROL_RESET;
			cfg_reg <= PINCFG_RESET;
		end
		else if (wb_ack_o && wb_we_i && wb_sel_i[0])
		begin
			if (wb_adr_i == CONTROL_ADDR)
				ctl_reg <= wb_dat_i[7:0];
			if (wb_adr_i == PINCFG_ADDR)
				cfg_reg <= wb_dat_i[7:0];
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_square_on;
		(ctl_reg[2:0] == MODE_SQUARE && cfg_reg[4:0] == 5'h01)[*4];
	endsequence
	a_ack_next:     assert property (s_req |=> wb_ack_o) else $error("ack late");
	a_ack_single:   assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
	a_ack_cause:    assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack unasked");
	a_read_upper:   assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h000000) else $error("upper bits");
	a_idle_float:   assert property ((!ctl_reg[0])[*4] |-> !pin_oe_o) else $error("idle pin driven");
	a_square_drive: assert property (s_square_on |-> pin_oe_o) else $error("square undriven");
	a_latch_off:    assert property ((!cfg_reg[0])[*4] |-> !pin_oe_o) else $error("latch ignored");
	a_open_off:     assert property (cfg_reg[1][*4] |-> !pin_oe_o) else $error("pin mode ignored");
	a_power_off:    assert property (cfg_reg[4][*4] |-> !pin_oe_o) else $error("power down ignored");
endmodule

// [dv/test_pwm_tone_generator.sv]
// Self-checking bench for the PWM and tone generator
`timescale 1ns/100ps
module test_pwm_tone_generator
	import pwm_tone_pkg::*;
;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        microsecond_tick_i = 1'b0;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic        wb_we_i = 1'b0;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [3:0]  wb_sel_i = 4'h1;
	logic [31:0] wb_dat_i = 32'h00000000;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic        pin_o;
	logic        pin_oe_o;
	logic        level;
	logic [31:0] rq;
	int          bad_count = 0;
	int          n_checks = 0;
	int          tdiv = 0;
	pwm_tone_generator i_pwm_tone_generator (.clk_i, .rst_i, .microsecond_tick_i, .wb_cyc_i, .wb_stb_i,
		.wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pin_o, .pin_oe_o);
	pwm_load_model i_pwm_load_model (.pin_i(pin_o), .oe_i(pin_oe_o), .level_o(level));
	// 250 MHz clock and a 1 MHz tick
	initial
	begin
		forever #2 clk_i = ~clk_i;
	end
	always @(posedge clk_i)
	begin
		tdiv <= (tdiv == 249) ? 0 : tdiv + 1;
		microsecond_tick_i <= (tdiv < 125);
	end
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
			bad_count++;
		end
	endtask
	// One classic cycle, held until ack is seen
	task automatic xf(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= {24'h000000, d};
		// No cycle count is assumed; only the watchdog ends a hung wait
		do
		begin
			@(posedge clk_i);
		end
		while (wb_ack_o !== 1'b1);
		rq = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		xf(1'b0, a, 8'h00);
		chk(rq, {24'h000000, e});
	endtask
	// Duty first, then mode; counts a window of whole waveform periods
	task automatic run(input logic [7:0] c, input logic [7:0] d, input int n, input int eo, input int eh);
		int o;
		int h;
		o = 0;
		h = 0;
		xf(1'b1, CONTROL_ADDR, 8'h10);
		xf(1'b1, LOW_ADDR, d);
		xf(1'b1, HIGH_ADDR, 8'h00);
		xf(1'b1, CONTROL_ADDR, c);
		repeat (600) @(posedge clk_i);
		repeat (n)
		begin
			@(posedge clk_i);
			o += (pin_oe_o === 1'b1);
			h += (level === 1'b1);
		end
		chk(o, eo);
		chk(h, eh);
	endtask
	initial
	begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(CONTROL_ADDR, CONTROL_RESET);
		rd(PINCFG_ADDR, PINCFG_RESET);
		xf(1'b1, 8'h40, 8'h5a);
		rd(8'h40, 8'h00);
		xf(1'b1, LOW_ADDR, 8'h05);
		xf(1'b1, HIGH_ADDR, 8'h00);
		xf(1'b1, CONTROL_ADDR, 8'h10);
		xf(1'b1, LOW_ADDR, 8'h09);
		rd(LOW_ADDR, 8'h00);
		xf(1'b1, HIGH_ADDR, 8'h01);
		rd(HIGH_ADDR, 8'h01);
		xf(1'b1, CONTROL_ADDR, 8'h00);
		rd(LOW_ADDR, 8'h05);
		run(8'h09, 8'h04, 60, 60, 40);
		run(8'h29, 8'h04, 60, 60, 20);
		run(8'h09, 8'h00, 60, 60, 0);
		run(8'h09, 8'h07, 60, 60, 60);
		run(8'h29, 8'h00, 60, 60, 60);
		run(8'h29, 8'h07, 60, 60, 0);
		run(8'h0b, 8'h04, 60, 60, 30);
		run(8'h0f, 8'h04, 60, 48, 36);
		run(8'h08, 8'h04, 60, 0, 60);
		run(8'h0d, 8'h04, 60, 0, 60);
		run(8'h01, 8'h04, 3000, 3000, 2000);
		// Disable mid-cycle, then enable with duty 1: the first tick must be high
		xf(1'b1, CONTROL_ADDR, 8'h10);
		xf(1'b1, LOW_ADDR, 8'h01);
		xf(1'b1, HIGH_ADDR, 8'h00);
		xf(1'b1, CONTROL_ADDR, 8'h09);
		repeat (2) @(posedge clk_i);
		chk({30'h00000000, pin_oe_o, pin_o}, 32'h00000003);
		@(posedge clk_i);
		chk({30'h00000000, pin_oe_o, pin_o}, 32'h00000002);
		xf(1'b1, PINCFG_ADDR, 8'h00);
		run(8'h09, 8'h04, 60, 0, 60);
		xf(1'b1, PINCFG_ADDR, 8'h03);
		run(8'h09, 8'h04, 60, 0, 60);
		xf(1'b1, PINCFG_ADDR, 8'h11);
		run(8'h09, 8'h04, 60, 0, 60);
		end_sim;
	end
	// Watchdog well beyond the expected run length
	initial
	begin
		#240000;
		bad_count++;
		end_sim;
	end
endmodule
bind pwm_tone_generator pwm_tone_checker i_pwm_tone_checker (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pin_oe_o);
